// *** hw/lfs_supervisor.sv ***
// Fault supervision and shutdown sequencing for a boost LED driver.
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int unsigned SHUTDOWN_HOLD = SHUTDOWN_HOLD_CYCLES,
  parameter int unsigned SINGLE_LIMIT = SINGLE_LIMIT_CYCLES,
  parameter int unsigned UNDERVOLTAGE_LOCKOUT_FALL = UNDERVOLTAGE_LOCKOUT_FALL_CYCLES,
  parameter int unsigned STARTUP_MASK = STARTUP_MASK_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire lfs_sense_t sense,
  input wire logic cycleStart,
  input wire logic ledDetectDone,
  output lfs_drive_t drive,
  output logic errFlagOut,
  output logic errFlagOe,
  output lfs_latch_t latched,
  output lfs_state_t seqState
);

  typedef struct packed {
    lfs_state_t state;
    logic powerOk;
    logic cycleCut;
    lfs_latch_t latch;
    lfs_drive_t drive;
    logic flagLow;
  } lfs_sup_t;

  lfs_sup_t st;
  lfs_sup_t next_st;
  lfs_sense_t pin;
  logic enLowDone;
  logic syncStop;
  logic uvloFallDone;
  logic singleExpired;
  logic maskDone;
  logic fullShutdown;
  logic singleActive;
  logic singleRun;
  logic anyLatch;
  logic powered;

  if (SHUTDOWN_HOLD < 2 || SINGLE_LIMIT < 2 || UNDERVOLTAGE_LOCKOUT_FALL < 2 || STARTUP_MASK < 2)
  begin : g_count_check
    $error("lfs_supervisor timing counts must be at least two cycles");
  end

  // Hardware set beats a clear arriving in the same cycle.
  function automatic logic latch_next(input logic set, input logic held, input logic clear);
    latch_next = set | (held & ~clear);
  endfunction

  // Every comparator and host pin is asynchronous to ref_clk.
  lfs_pin_sync #(
    .WIDTH($bits(lfs_sense_t))
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async(sense),
    .level(pin)
  );

  lfs_timer #(
    .LIMIT(SHUTDOWN_HOLD),
    .WIDTH($clog2(SHUTDOWN_HOLD + 1))
  ) u_en_low (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(~pin.enDimPin),
    .done(enLowDone)
  );

  lfs_timer #(
    .LIMIT(SYNC_STOP_CYCLES),
    .WIDTH($clog2(SYNC_STOP_CYCLES + 1))
  ) u_sync_low (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(~pin.freqSetSyncPin),
    .done(syncStop)
  );

  lfs_timer #(
    .LIMIT(UNDERVOLTAGE_LOCKOUT_FALL),
    .WIDTH($clog2(UNDERVOLTAGE_LOCKOUT_FALL + 1))
  ) u_undervoltage_lockout_fall (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(pin.supplyBelowFall),
    .done(uvloFallDone)
  );

  lfs_timer #(
    .LIMIT(SINGLE_LIMIT),
    .WIDTH($clog2(SINGLE_LIMIT + 1))
  ) u_single (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(singleRun),
    .done(singleExpired)
  );

  lfs_timer #(
    .LIMIT(STARTUP_MASK),
    .WIDTH($clog2(STARTUP_MASK + 1))
  ) u_mask (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(st.state == LFS_RUN),
    .done(maskDone)
  );

  // Decoded conditions shared by the sequencer.
  always_comb
  begin
    powered = (st.state != LFS_OFF);
    anyLatch = |st.latch;
    fullShutdown = enLowDone | ~st.powerOk;
    singleActive = (st.state == LFS_RUN) & maskDone & pin.inCurSingle & ~pin.inCurDouble;
    singleRun = singleActive & ~anyLatch;
  end

  // Sequencer, fault latches and registered outputs.
  always_comb
  begin
    next_st = st;

    if (pin.supplyAboveRise && pin.senseAboveRise && !pin.supplyBelowMin && !uvloFallDone)
    begin
      next_st.powerOk = 1'b1;
    end
    if (uvloFallDone || pin.supplyBelowMin)
    begin
      next_st.powerOk = 1'b0;
    end

    next_st.latch.overVolt = latch_next(powered & pin.swOverVolt, st.latch.overVolt, fullShutdown);
    next_st.latch.curLimit2 = latch_next(powered & pin.swCurLimit2, st.latch.curLimit2, fullShutdown);
    next_st.latch.doubleTrip = latch_next(powered & pin.inCurDouble, st.latch.doubleTrip, fullShutdown);
    next_st.latch.singleTimeout = latch_next(singleRun & singleExpired, st.latch.singleTimeout, fullShutdown);

    next_st.cycleCut = pin.swCurLimit | (st.cycleCut & ~cycleStart);

    case (st.state)
      LFS_OFF:
      begin
        if (pin.enDimPin && st.powerOk && !enLowDone)
        begin
          next_st.state = LFS_DETECT;
        end
      end
      LFS_DETECT:
      begin
        if (ledDetectDone)
        begin
          next_st.state = LFS_RUN;
        end
      end
      LFS_RUN:
      begin
        if (anyLatch)
        begin
          next_st.state = LFS_FAULT;
        end
      end
      LFS_FAULT:
      begin
        if (!anyLatch)
        begin
          next_st.state = LFS_RUN;
        end
      end
      default:
      begin
        next_st.state = LFS_OFF;
      end
    endcase

    if (fullShutdown)
    begin
      next_st.state = LFS_OFF;
    end

    // Outputs follow next state and next latches so a trip acts on the following edge.
    next_st.drive = '0;
    next_st.drive.lowPower = (next_st.state == LFS_OFF);
    next_st.drive.ledDetectStart = (next_st.state == LFS_DETECT);
    if ((next_st.state == LFS_DETECT || next_st.state == LFS_RUN) && !(|next_st.latch))
    begin
      if (!syncStop)
      begin
        next_st.drive.disconnectDrive = 1'b1;
        next_st.drive.disconnectLimit = singleActive;
        if (next_st.state == LFS_RUN)
        begin
          next_st.drive.boostEnable = ~next_st.cycleCut & ~pin.swCurLimit2;
          next_st.drive.sinkEnable = pin.enDimPin;
        end
      end
    end

    next_st.flagLow = (|next_st.latch) | singleActive;
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '{state: LFS_OFF, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign errFlagOut = 1'b0;
  assign errFlagOe = st.flagLow;
  assign drive = st.drive;
  assign latched = st.latch;
  assign seqState = st.state;

endmodule

// *** include/lfs_pkg.sv ***
// Shared types and constants for the LED driver fault supervisor.
package lfs_pkg;

  // Clock rate of ref_clk, in nanoseconds per cycle.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Enable-low hold that forces low-power shutdown, in clock cycles.
  localparam int unsigned SHUTDOWN_HOLD_CYCLES = 32750;

  // Longest stay in single-limit current mode, in clock cycles.
  localparam int unsigned SINGLE_LIMIT_CYCLES = 10000;

  // Sync pin low time that stops the device; it must be exceeded.
  localparam int unsigned SYNC_STOP_TIME_NS = 7000;
  localparam int unsigned SYNC_STOP_CYCLES = (SYNC_STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  // Supply glitch filter for the falling lockout threshold; it must be exceeded.
  localparam int unsigned UNDERVOLTAGE_LOCKOUT_FALL_TIME_NS = 50000;
  localparam int unsigned UNDERVOLTAGE_LOCKOUT_FALL_CYCLES = (UNDERVOLTAGE_LOCKOUT_FALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  // Startup window in which single-limit current detection is masked.
  localparam int unsigned STARTUP_MASK_CYCLES = 1024;

  // Supervisor sequence states, one-hot.
  typedef enum logic [3:0] {
    LFS_OFF = 4'h1,
    LFS_DETECT = 4'h2,
    LFS_RUN = 4'h4,
    LFS_FAULT = 4'h8
  } lfs_state_t;

  // Comparator and host pin levels, all from outside the clock domain.
  typedef struct packed {
    logic swOverVolt;
    logic swCurLimit;
    logic swCurLimit2;
    logic inCurSingle;
    logic inCurDouble;
    logic supplyAboveRise;
    logic senseAboveRise;
    logic supplyBelowFall;
    logic supplyBelowMin;
    logic enDimPin;
    logic freqSetSyncPin;
  } lfs_sense_t;

  // Power stage controls.
  typedef struct packed {
    logic boostEnable;
    logic disconnectDrive;
    logic disconnectLimit;
    logic sinkEnable;
    logic ledDetectStart;
    logic lowPower;
  } lfs_drive_t;

  // Latched faults, each cleared only by a full shutdown.
  typedef struct packed {
    logic overVolt;
    logic curLimit2;
    logic doubleTrip;
    logic singleTimeout;
  } lfs_latch_t;

endpackage

// *** hw/lfs_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous levels.
module lfs_pin_sync
  import lfs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
    logic [WIDTH-1:0] third;
    logic [WIDTH-1:0] level;
  } lfs_sync_t;

  lfs_sync_t st;
  lfs_sync_t next_st;

  if (WIDTH < 1)
  begin : g_width_check
    $error("lfs_pin_sync needs WIDTH of at least one");
  end

  // The first stage feeds only the second; a change counts once stages two and three agree.
  always_comb
  begin
    next_st = st;
    next_st.first = async;
    next_st.second = st.first;
    next_st.third = st.second;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st.second[i] == st.third[i])
      begin
        next_st.level[i] = st.third[i];
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// *** hw/lfs_timer.sv ***
// Saturating duration timer that reports when a condition has held long enough.
module lfs_timer
  import lfs_pkg::*;
#(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned WIDTH = 5
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  output logic done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } lfs_tmr_t;

  lfs_tmr_t st;
  lfs_tmr_t next_st;

  if (LIMIT < 1 || LIMIT >= (64'h1 << WIDTH))
  begin : g_limit_check
    $error("lfs_timer LIMIT must be at least one and fit in WIDTH bits");
  end

  // Counts consecutive cycles of run and holds at the limit; any gap restarts it.
  always_comb
  begin
    next_st = st;
    if (!run)
    begin
      next_st.count = '0;
    end
    else if (st.count != WIDTH'(LIMIT))
    begin
      next_st.count = st.count + WIDTH'(1);
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done = (st.count == WIDTH'(LIMIT));

endmodule

// *** test/lfs_supervisor_properties.sv ***
// Concurrent checks on the fault supervisor ports.
module lfs_supervisor_properties
  import lfs_pkg::*;
#(
  parameter int unsigned SHUTDOWN_HOLD = 20
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire lfs_sense_t sense,
  input wire logic cycleStart,
  input wire logic ledDetectDone,
  input wire lfs_drive_t drive,
  input wire logic errFlagOut,
  input wire logic errFlagOe,
  input wire lfs_latch_t latched,
  input wire lfs_state_t seqState
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] syncLow;
  logic [15:0] enLow;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Low-time counters saturate, so a very long hold never wraps below the limit.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncLow <= '0;
      enLow <= '0;
    end
    else
    begin
      syncLow <= sense.freqSetSyncPin ? '0 : syncLow + {9'h0, ~&syncLow};
      enLow <= sense.enDimPin ? '0 : enLow + {15'h0, ~&enLow};
    end
  end
  // A fault counts only once it has been seen in normal operation for the sync delay.
  sequence ovpHeld;
    (sense.swOverVolt && seqState == LFS_RUN) [*5];
  endsequence
  sequence dblHeld;
    (sense.inCurDouble && seqState == LFS_RUN) [*5];
  endsequence
  AST_OVP_LATCH: assert property (ovpHeld |=> latched.overVolt)
    else $error("overvoltage not latched");
  AST_DOUBLE_TRIP: assert property (dblHeld |=> latched.doubleTrip)
    else $error("double limit not latched");
  AST_ALL_OFF: assert property (|latched |-> !(drive.boostEnable || drive.disconnectDrive || drive.sinkEnable))
    else $error("stage on while latched");
  AST_FLAG: assert property (|latched |-> errFlagOe && !errFlagOut)
    else $error("flag missing while latched");
  AST_SINGLE_FLAG: assert property ($rose(drive.disconnectLimit) |-> errFlagOe)
    else $error("flag late in single limit mode");
  AST_CLEAR_ONLY_OFF: assert property ($fell(|latched) |-> seqState == LFS_OFF)
    else $error("latch cleared outside shutdown");
  AST_DETECT_FIRST: assert property (drive.boostEnable |-> seqState == LFS_RUN && $past(seqState) != LFS_OFF)
    else $error("boost before detection");
  AST_CYCLE_CUT: assert property (sense.swCurLimit [*6] |-> !drive.boostEnable)
    else $error("boost on at switch limit");
  AST_SYNC_STOP: assert property (syncLow > 10'h2C6 |-> !(drive.boostEnable || drive.sinkEnable))
    else $error("still running after sync stop");
  AST_SHUTDOWN: assert property (enLow > 16'(SHUTDOWN_HOLD + 5) |-> drive.lowPower && latched == '0)
    else $error("no shutdown after enable hold");
  AST_UNDERVOLTAGE_LOCKOUT_MIN: assert property (sense.supplyBelowMin [*7] |-> seqState == LFS_OFF)
    else $error("running below minimum supply");
endmodule
bind lfs_supervisor lfs_supervisor_properties #(.SHUTDOWN_HOLD(SHUTDOWN_HOLD)) u_props (.ref_clk(ref_clk),
  .rst(rst), .sense(sense), .cycleStart(cycleStart), .ledDetectDone(ledDetectDone), .drive(drive),
  .errFlagOut(errFlagOut), .errFlagOe(errFlagOe), .latched(latched), .seqState(seqState));

// *** test/lfs_host_model.sv ***
// Host controller model driving the enable/dimming and sync pins.
module lfs_host_model
(
  input wire logic ref_clk,
  input wire logic enReq,
  input wire logic syncReq,
  output logic enDimPin,
  output logic freqSetSyncPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en = 1'b0;
  logic sync = 1'b1;
  assign enDimPin = en;
  assign freqSetSyncPin = sync;
  // Pins follow requests one edge later, like a port register in the controller.
  // enable hold
  always @(posedge ref_clk)
  begin
    en <= enReq;
    sync <= syncReq;
  end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the LED driver fault supervisor.
module tb_top;
  import lfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  lfs_sense_t sns = '0;
  lfs_sense_t sense;
  logic cycleStart = 1'b0;
  logic ledDetectDone = 1'b0;
  logic enReq = 1'b0;
  logic syncReq = 1'b1;
  logic hostEn;
  logic hostSync;
  lfs_drive_t drive;
  logic errFlagOe;
  logic errFlagOut;
  lfs_latch_t latched;
  lfs_state_t seqState;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  int expLat = 0;
  lfs_state_t expSt = LFS_OFF;
  logic expLim = 1'b0;
  logic expOn = 1'b0;
  logic expStop = 1'b0;
  int senseIdx[$] = '{10, 8, 6};
  always #5 ref_clk = ~ref_clk;
  // Host pins come from the partner model; the bench owns the comparator levels.
  always_comb
  begin
    sense = sns;
    sense.enDimPin = hostEn;
    sense.freqSetSyncPin = hostSync;
  end
  lfs_host_model u_host (.ref_clk(ref_clk), .enReq(enReq), .syncReq(syncReq), .enDimPin(hostEn),
    .freqSetSyncPin(hostSync));
  lfs_supervisor #(.SHUTDOWN_HOLD(HOLD), .SINGLE_LIMIT(30), .UNDERVOLTAGE_LOCKOUT_FALL(20), .STARTUP_MASK(8)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .sense(sense), .cycleStart(cycleStart), .ledDetectDone(ledDetectDone),
    .drive(drive), .errFlagOut(errFlagOut), .errFlagOe(errFlagOe), .latched(latched), .seqState(seqState));
  // A hung sequence is cut short and reported as a mismatch.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Compare with the bench model after the edge settles, then realign to an edge.
  task automatic model;
    logic live;
    #1;
    // Disconnect and sinks run only while active, unlatched and not stopped by the sync pin.
    live = (expSt == LFS_DETECT || expSt == LFS_RUN) && expLat == 0 && !expStop;
    chk("state", 8'(seqState), 8'(expSt));
    chk("latch", 8'(latched), 8'(expLat));
    chk("flag", 8'(errFlagOe), 8'(expLat != 0 || expLim));
    chk("limit", 8'(drive.disconnectLimit), 8'(expLim));
    chk("boost", 8'(drive.boostEnable), 8'(expOn));
    chk("lowpower", 8'(drive.lowPower), 8'(expSt == LFS_OFF));
    chk("disconnect", 8'(drive.disconnectDrive), 8'(live));
    chk("sink", 8'(drive.sinkEnable), 8'(live && expSt == LFS_RUN));
    chk("detect", 8'(drive.ledDetectStart), 8'(expSt == LFS_DETECT));
    chk("flag data", 8'(errFlagOut), 8'h00);
    @(posedge ref_clk);
  endtask
  // Detection must finish before the boost may run.
  task automatic startUp;
    enReq <= 1'b1;
    sns.senseAboveRise <= 1'b1;
    // Enable passes the host register, the synchroniser and the hold timer before detection.
    tick(8);
    expSt = LFS_DETECT;
    model();
    ledDetectDone <= 1'b1;
    tick(3);
    expSt = LFS_RUN;
    expOn = 1'b1;
    model();
  endtask
  // A long enable-low hold clears the latches, as does a supply lockout.
  task automatic restart;
    enReq <= 1'b0;
    ledDetectDone <= 1'b0;
    tick(HOLD + 10);
    expLat = 0;
    expLim = 1'b0;
    expOn = 1'b0;
    expSt = LFS_OFF;
    model();
    startUp();
  endtask
  initial
  begin
    void'($urandom(32'hD12CAF72));
    tick(2);
    rst <= 1'b0;
    sns.supplyAboveRise <= 1'b1;
    enReq <= 1'b1;
    tick(10);
    model();
    startUp();
    foreach (senseIdx[i])
    begin
      sns[senseIdx[i]] <= 1'b1;
      tick(8);
      expLat = 1 << (3 - i);
      expSt = LFS_FAULT;
      expOn = 1'b0;
      model();
      sns[senseIdx[i]] <= 1'b0;
      tick(10);
      model();
      restart();
    end
    tick(10);
    sns.inCurSingle <= 1'b1;
    tick(5 + $urandom_range(15));
    expLim = 1'b1;
    model();
    sns.inCurSingle <= 1'b0;
    tick(6);
    expLim = 1'b0;
    model();
    sns.inCurSingle <= 1'b1;
    tick(45);
    expLat = 1;
    expSt = LFS_FAULT;
    expOn = 1'b0;
    model();
    // Single-limit input stays high into the restart, so the startup mask must hide it.
    restart();
    model();
    sns.inCurSingle <= 1'b0;
    sns.swCurLimit <= 1'b1;
    tick(6);
    expOn = 1'b0;
    model();
    sns.swCurLimit <= 1'b0;
    tick(6);
    model();
    cycleStart <= 1'b1;
    tick(1);
    cycleStart <= 1'b0;
    tick(2);
    expOn = 1'b1;
    model();
    syncReq <= 1'b0;
    tick(720);
    expOn = 1'b0;
    expStop = 1'b1;
    model();
    syncReq <= 1'b1;
    tick(8);
    expOn = 1'b1;
    expStop = 1'b0;
    model();
    sns.supplyBelowFall <= 1'b1;
    tick(2 + $urandom_range(10));
    sns.supplyBelowFall <= 1'b0;
    tick(4);
    model();
    sns.supplyBelowFall <= 1'b1;
    tick(30);
    expSt = LFS_OFF;
    expOn = 1'b0;
    model();
    sns.supplyBelowFall <= 1'b0;
    tick(10);
    expSt = LFS_RUN;
    expOn = 1'b1;
    model();
    sns.supplyBelowMin <= 1'b1;
    tick(6);
    expSt = LFS_OFF;
    expOn = 1'b0;
    model();
    tick(4);
    summarize();
  end
endmodule
